// ==== src/tsm_pkg.sv ====
// package: constants for the table-driven state machine
// ****************************************
// How it works
// - reset and initialisation put the machine in the configured start state, zero unless configured otherwise.
// - states are integer indices counted from zero, and each table entry names its destination by index.
// - the table holds one definition per state, so the definition count equals the state count.
// - each state fixes the value of every output bit, so the outputs follow the current state alone.
// - each output bit is one of twelve codes, a level of 0, 1 or unknown with a strength of strong, resistive, high-z or undefined.
// - the next state comes from matching the inputs against the current state's patterns, where x matches either level.
// - input and output widths are parameters, and every entry has one symbol per input and one code per output.
// - the default table is a 2-bit up/down counter whose inputs are reset and direction and whose outputs are the state index.
// ****************************************
package tsm_pkg;
  // output level codes
  localparam logic [1:0] TSM_LVL_0 = 2'h0;
  localparam logic [1:0] TSM_LVL_1 = 2'h1;
  localparam logic [1:0] TSM_LVL_U = 2'h2;
  // output strength codes
  localparam logic [1:0] TSM_STR_S = 2'h0;
  localparam logic [1:0] TSM_STR_R = 2'h1;
  localparam logic [1:0] TSM_STR_Z = 2'h2;
  localparam logic [1:0] TSM_STR_U = 2'h3;
  localparam int TSM_CODE_W = 4;  // level in [3:2], strength in [1:0]
  localparam int TSM_RESET_STATE = 0;
  // default table sizes: the 2-bit up/down counter
  localparam int TSM_NUM_IN = 2;
  localparam int TSM_NUM_OUT = 2;
  localparam int TSM_NUM_STATES = 4;
  localparam int TSM_PATS_PER_STATE = 4;
  // pattern symbol: care bit in [1], level in [0]
  localparam logic [1:0] TSM_SYM_0 = 2'h2;
  localparam logic [1:0] TSM_SYM_1 = 2'h3;
  localparam logic [1:0] TSM_SYM_X = 2'h0;
endpackage

// ==== src/tsm_match.sv ====
// module: matches one input vector against one pattern
`timescale 1ns/1ps
module tsm_match
  import tsm_pkg::*;
#(
  parameter int NUM_IN = TSM_NUM_IN
) (
  input  wire logic [2*NUM_IN-1:0] pattern_in,
  input  wire logic [NUM_IN-1:0]   inputs_in,
  output logic                     hit_out
);
  logic [NUM_IN-1:0] bit_ok;
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_bit
      // don't care accepts either level
      assign bit_ok[g] = !pattern_in[2*g+1] || (pattern_in[2*g] == inputs_in[g]);
    end
  endgenerate
  assign hit_out = &bit_ok;
endmodule

// ==== src/tsm_top.sv ====
// module: table-driven moore state machine
`timescale 1ns/1ps
module tsm_top
  import tsm_pkg::*;
#(
  parameter int NUM_IN      = TSM_NUM_IN,
  parameter int NUM_OUT     = TSM_NUM_OUT,
  parameter int NUM_STATES  = TSM_NUM_STATES,
  parameter int PATS        = TSM_PATS_PER_STATE,
  parameter int RESET_STATE = TSM_RESET_STATE,
  parameter int SW          = (NUM_STATES > 1) ? $clog2(NUM_STATES) : 1,
  // one output word per state, bit o code at [4*o +: 4]
  parameter logic [NUM_STATES*NUM_OUT*TSM_CODE_W-1:0] OUT_TABLE = {
    TSM_LVL_1, TSM_STR_S, TSM_LVL_1, TSM_STR_S,
    TSM_LVL_1, TSM_STR_S, TSM_LVL_0, TSM_STR_S,
    TSM_LVL_0, TSM_STR_S, TSM_LVL_1, TSM_STR_S,
    TSM_LVL_0, TSM_STR_S, TSM_LVL_0, TSM_STR_S},
  // per state, per pattern: symbols; input 0 is direction, input 1 is reset
  parameter logic [NUM_STATES*PATS*2*NUM_IN-1:0] PAT_TABLE = {
    {4{TSM_SYM_1, TSM_SYM_1, TSM_SYM_1, TSM_SYM_0, TSM_SYM_0, TSM_SYM_1, TSM_SYM_0, TSM_SYM_0}}},
  // per state, per pattern: destination index
  parameter logic [NUM_STATES*PATS*SW-1:0] DEST_TABLE = {
    2'h0, 2'h0, 2'h0, 2'h2,
    2'h0, 2'h0, 2'h3, 2'h1,
    2'h0, 2'h0, 2'h2, 2'h0,
    2'h0, 2'h0, 2'h1, 2'h3}
) (
  input  wire logic                          core_clk_in,
  input  wire logic                          reset_in,
  input  wire logic [NUM_IN-1:0]             inputs_in,
  output logic [NUM_OUT-1:0]                 level_out,
  output logic [NUM_OUT-1:0]                 level_unknown_out,
  output logic [NUM_OUT*2-1:0]               strength_out,
  output logic [SW-1:0]                      state_index_out
);
  // ****************************************
  // input sampling
  // ****************************************
  typedef struct packed {
    logic [NUM_IN-1:0] sync1;
    logic [NUM_IN-1:0] sync2;
    logic [SW-1:0]     state_index;
    // sync stages hold cleared values, not real inputs, for two edges after reset
    logic [1:0]        primed;
  } tsm_state_s;

  localparam logic [SW-1:0] START = SW'(RESET_STATE);

  tsm_state_s cur;
  tsm_state_s next_cur;

  // ****************************************
  // pattern match, one matcher per entry of the current state
  // ****************************************
  logic [PATS-1:0]    hit;
  logic [PATS*SW-1:0] dest_row;
  logic [PATS*2*NUM_IN-1:0] pat_row;
  assign pat_row  = PAT_TABLE[cur.state_index*PATS*2*NUM_IN +: PATS*2*NUM_IN];
  assign dest_row = DEST_TABLE[cur.state_index*PATS*SW +: PATS*SW];
  genvar p;
  generate
    for (p = 0; p < PATS; p++) begin : g_pat
      tsm_match #(
        .NUM_IN(NUM_IN)
      ) u_match (
        .pattern_in (pat_row[p*2*NUM_IN +: 2*NUM_IN]),
        .inputs_in  (cur.sync2),
        .hit_out    (hit[p])
      );
    end
  endgenerate

  // ****************************************
  // next state: first matching entry wins, hold when none
  // ****************************************
  always_comb begin
    next_cur             = cur;
    next_cur.sync1       = inputs_in;
    next_cur.sync2       = cur.sync1;
    next_cur.primed      = {cur.primed[0], 1'b1};
    next_cur.state_index = cur.state_index;
    for (int i = PATS - 1; i >= 0; i--) begin
      if (hit[i] && cur.primed[1]) begin
        next_cur.state_index = dest_row[i*SW +: SW];
      end
    end
  end

  // async reset dominates clock and table
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cur.sync1       <= '0;
      cur.sync2       <= '0;
      cur.primed      <= 2'h0;
      cur.state_index <= START;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // moore outputs straight from the table
  // ****************************************
  logic [NUM_OUT*TSM_CODE_W-1:0] out_row;
  assign out_row = OUT_TABLE[cur.state_index*NUM_OUT*TSM_CODE_W +: NUM_OUT*TSM_CODE_W];
  genvar o;
  generate
    for (o = 0; o < NUM_OUT; o++) begin : g_out
      // unknown level is flagged apart since hardware cannot drive x
      assign level_out[o]         = (out_row[o*4+2 +: 2] == TSM_LVL_1);
      assign level_unknown_out[o] = (out_row[o*4+2 +: 2] == TSM_LVL_U);
      assign strength_out[o*2 +: 2] = out_row[o*4 +: 2];
    end
  endgenerate
  assign state_index_out = cur.state_index;
endmodule

// ==== bench/tsm_top_checker.sv ====
// checker: port properties of the state machine
`timescale 1ns/1ps
module tsm_checker
  import tsm_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic [1:0] inputs_in,
  input wire logic [1:0] level_out,
  input wire logic [1:0] level_unknown_out,
  input wire logic [3:0] strength_out,
  input wire logic [1:0] state_index_out
);
  // cleared sync stages act for two edges after release, so skip them
  logic [1:0] age;
  always_ff @(posedge core_clk_in or posedge reset_in)
    if (reset_in) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  property p_up; age == 2'h3 && $past(inputs_in, 2) == 2'h1 |=> state_index_out == 2'($past(state_index_out) + 2'h1);
  endproperty
  a_up: assert property (p_up) else $error("count up wrong");
  property p_dn; age == 2'h3 && $past(inputs_in, 2) == 2'h0 |=> state_index_out == 2'($past(state_index_out) - 2'h1);
  endproperty
  a_dn: assert property (p_dn) else $error("count down wrong");
  property p_clr; age == 2'h3 && $past(inputs_in, 2) > 2'h1 |=> state_index_out == 2'h0; endproperty
  a_clr: assert property (p_clr) else $error("table clear wrong");
  property p_rst; disable iff (1'b0) reset_in |-> state_index_out == 2'(TSM_RESET_STATE); endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_hold; disable iff (1'b0) reset_in [*2] |-> $stable(state_index_out); endproperty
  a_hold: assert property (p_hold) else $error("state moved in reset");
  property p_rel; $fell(reset_in) |-> state_index_out == 2'h0 && level_out == 2'h0; endproperty
  a_rel: assert property (p_rel) else $error("start state lost");
  property p_lvl; level_out == state_index_out; endproperty
  a_lvl: assert property (p_lvl) else $error("level not state");
  property p_str; strength_out == 4'h0 && level_unknown_out == 2'h0; endproperty
  a_str: assert property (p_str) else $error("strength wrong");
endmodule
bind tsm_top tsm_checker i_chk (.core_clk_in(core_clk_in), .reset_in(reset_in), .inputs_in(inputs_in),
  .level_out(level_out), .level_unknown_out(level_unknown_out), .strength_out(strength_out),
  .state_index_out(state_index_out));

// ==== bench/tsm_tb.sv ====
// testbench: counter table driven through the ports
`timescale 1ns/1ps
module tb_top;
  logic       core_clk_in = 1'b0;
  logic       reset_in = 1'b0;
  logic [1:0] inputs_in = 2'h2;
  logic [1:0] level_out, level_unknown_out, state_index_out;
  logic [3:0] strength_out;
  int         failures = 0;
  int         checked = 0;
  tsm_top i_dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .inputs_in(inputs_in), .level_out(level_out),
    .level_unknown_out(level_unknown_out), .strength_out(strength_out), .state_index_out(state_index_out));
  initial begin
    forever #10 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input string n, input logic [1:0] e, input logic [1:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // inputs act on the third edge: two sync stages then the state register
  task automatic run(input logic [1:0] v, input logic [1:0] d);
    logic [1:0] e;
    inputs_in = 2'h2;
    repeat (4) @(negedge core_clk_in);
    chk("state", 2'h0, state_index_out);
    inputs_in = v;
    e = 2'h0;
    repeat (2) @(negedge core_clk_in);
    repeat (4) begin
      @(negedge core_clk_in);
      e = e + d;
      chk("state", e, state_index_out);
      chk("level", e, level_out);
      chk("unknown", 2'h0, level_unknown_out);
      chk("strength1", tsm_pkg::TSM_STR_S, strength_out[3:2]);
      chk("strength0", tsm_pkg::TSM_STR_S, strength_out[1:0]);
    end
  endtask
  task automatic t_clr;
    run(2'h1, 2'h1);
    inputs_in = 2'h3;
    repeat (2) @(negedge core_clk_in);
    chk("late", 2'h2, state_index_out);
    @(negedge core_clk_in);
    chk("clear", 2'h0, state_index_out);
  endtask
  task automatic t_rst;
    inputs_in = 2'h1;
    repeat (5) @(negedge core_clk_in);
    reset_in = 1'b1;
    #1 chk("async", 2'h0, state_index_out);
    repeat (3) @(negedge core_clk_in);
    chk("held", 2'h0, state_index_out);
    reset_in = 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    close_out();
  end
  initial begin
    // a rising edge on reset lets the async branch clear the state before the first clock
    #1 reset_in = 1'b1;
    repeat (20) @(negedge core_clk_in);
    reset_in = 1'b0;
    run(2'h1, 2'h1);
    run(2'h0, 2'h3);
    t_clr();
    t_rst();
    run(2'h1, 2'h1);
    close_out();
  end
endmodule
